//--- shared/rscu_pkg.sv
// Package of constants and types for the reset source and start-up control
`default_nettype none
package rscu_pkg;
    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned POWERUP_TIMER_MS = 64;
    localparam int unsigned POWERUP_TIMER_CYCLES = POWERUP_TIMER_MS * CLK_KHZ;
    localparam int unsigned FILT_NS = 200;
    localparam int unsigned FILT_CYCLES =
        (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OST_CYCLES = 1024;
    localparam int unsigned WDT_CYCLES = 40000;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CAUSE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // ==========================================================
    // Config register fields
    localparam int CFG_EXT_RESET_EN = 0;
    localparam int CFG_LV_PROG_EN = 1;
    localparam int CFG_STACK_RESET_EN = 2;
    localparam int CFG_POWERUP_TIMER_EN = 3;
    localparam int CFG_OST_NEEDED = 4;
    localparam int CFG_WDT_EN = 5;
    localparam int CFG_SW_PULLUP = 6;
    localparam logic [6:0] CFG_RESET = 7'h39;

    // ==========================================================
    // Reset cause register fields
    localparam int CAU_STK_OVER = 7;
    localparam int CAU_STK_UNDER = 6;
    localparam int CAU_WDT = 4;
    localparam int CAU_PIN = 3;
    localparam int CAU_INSTR = 2;
    localparam int CAU_POR = 1;
    localparam int CAU_BOR = 0;
    localparam logic [7:0] CAU_IMPL_MASK = 8'hDF;
    localparam logic [7:0] CAU_POR_VAL = 8'h1C;

    // ==========================================================
    // Status register fields
    localparam int STA_TIMEOUT = 4;
    localparam int STA_POWERDOWN = 3;
    localparam int STA_PIN_EN = 1;
    localparam int STA_PIN_LEVEL = 0;

    // ==========================================================
    // Bus answers and program counter targets
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] PC_RESTART = 16'h0000;
    localparam logic [15:0] PC_IRQ_VECTOR = 16'h0004;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_COLD,
        ST_WAIT,
        ST_RUN,
        ST_WARM
    } rscu_state_e;
endpackage
`default_nettype wire

//--- shared/rscu_pin_if.sv
// Interface between the sequencer and the reset pin filter
`timescale 1ns/1ps
`default_nettype none
interface rscu_pin_if;
    logic raw_pin;
    logic sync_level;
    logic filt_low;

    modport filter (input raw_pin, output sync_level, output filt_low);
    modport ctrl (output raw_pin, input sync_level, input filt_low);
endinterface
`default_nettype wire

//--- core/rscu_pin_filter.sv
// Synchroniser and noise filter for the external reset pin
`timescale 1ns/1ps
`default_nettype none
module rscu_pin_filter #(
    parameter int unsigned FILT_CYCLES = rscu_pkg::FILT_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pin side
    rscu_pin_if.filter pin
);
    import rscu_pkg::*;

    localparam int CW = $clog2(FILT_CYCLES + 1);
    localparam logic [CW-1:0] FILT_MAX = CW'(FILT_CYCLES);

    logic meta;
    logic sync;
    logic stable;
    logic [CW-1:0] cnt;

    // ==========================================================
    // Two-flop synchroniser, pin idles high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b1;
            sync <= 1'b1;
        end else begin
            meta <= pin.raw_pin;
            sync <= meta;
        end
    end

    // ==========================================================
    // ignore short pulses
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            stable <= 1'b1;
        end else if (sync == stable) begin
            cnt <= '0;
        end else if (cnt >= FILT_MAX - CW'(1)) begin
            cnt <= '0;
            stable <= sync;
        end else begin
            cnt <= cnt + CW'(1);
        end
    end

    assign pin.sync_level = sync;
    assign pin.filt_low = ~stable;
endmodule
`default_nettype wire

//--- core/rscu_top.sv
// Reset source selection, start-up sequencing and reset cause recording
//
// Behaviour
// - Pin reset off only if both bits 0
// - Low enabled pin holds reset
// - Short pin pulses ignored
// - Pin never driven
// - Disabled pin: input, software pull-up
// - Watchdog expiry resets, sets status
// - Reset instruction clears its flag
// - Enabled stack faults reset, set flag
// - Programming exit acts as power-on
// - Power-up delay only when enabled
// - Run after timers and pin release
// - Timers ignore pin level
// - Resets record cause, restart at zero
// - Power-on and prog exit load fixed causes; brown-out keeps WDT, POR bits
// - Watchdog reset or wake clears flags
// - Pin reset flag; sleep status
// - Irq wake resumes, vectors if enabled
// - Power-up timer nominal 64 ms
// - Hardware clears flags, firmware rearms
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rscu_top #(
    parameter int unsigned POWERUP_TIMER_CYCLES = rscu_pkg::POWERUP_TIMER_CYCLES,
    parameter int unsigned OST_CYCLES = rscu_pkg::OST_CYCLES,
    parameter int unsigned WDT_CYCLES = rscu_pkg::WDT_CYCLES,
    parameter int unsigned FILT_CYCLES = rscu_pkg::FILT_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Power detectors and programming mode (asynchronous)
    input wire logic por_i,
    input wire logic bor_i,
    input wire logic prog_mode_i,
    // External reset pin, input only
    input wire logic ext_reset_pin_i,
    output logic pullup_en_o,
    // Core events (same clock)
    input wire logic watchdog_clear_instr_i,
    input wire logic reset_instr_i,
    input wire logic stack_over_i,
    input wire logic stack_under_i,
    input wire logic sleep_i,
    input wire logic irq_wake_i,
    input wire logic global_irq_enable_i,
    // Core control
    output logic core_reset_o,
    output logic wake_resume_o,
    output logic irq_vector_o,
    output logic [15:0] pc_target_o
);
    import rscu_pkg::*;

    localparam int PW = $clog2(POWERUP_TIMER_CYCLES + 1);
    localparam int OW = $clog2(OST_CYCLES + 1);
    localparam int WW = $clog2(WDT_CYCLES + 1);
    localparam logic [PW-1:0] POWERUP_TIMER_MAX = PW'(POWERUP_TIMER_CYCLES);
    localparam logic [OW-1:0] OST_MAX = OW'(OST_CYCLES);
    localparam logic [WW-1:0] WDT_MAX = WW'(WDT_CYCLES);

    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] pwr_meta;
    logic [2:0] pwr_sync;
    logic [2:0] pwr_q;
    rscu_state_e state;
    rscu_state_e next_state;
    logic [6:0] cfg;
    logic [7:0] cause;
    logic [7:0] next_cause;
    logic timeout_flag;
    logic powerdown_flag;
    logic [PW-1:0] powerup_timer_cnt;
    logic [OW-1:0] ost_cnt;
    logic [WW-1:0] wdt_cnt;
    logic pin_en;
    logic pin_rst;
    logic cold_hold;
    logic por_ev;
    logic bor_ev;
    logic prog_exit;
    logic timers_done;
    logic running;
    logic wdt_expire;
    logic wdt_rst;
    logic wdt_wake;
    logic irq_wake;
    logic pin_ev;
    logic instr_ev;
    logic ovf_ev;
    logic unf_ev;
    logic warm_ok;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    logic aw_got;
    logic w_got;
    logic wr_en;
    logic [31:0] rd_mux;
    logic rd_hit;

    rscu_pin_if pin_bus ();

    // ==========================================================
    // Reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Synchronise power detectors and programming mode
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pwr_meta <= 3'b000;
            pwr_sync <= 3'b000;
            pwr_q <= 3'b000;
        end else begin
            pwr_meta <= {prog_mode_i, bor_i, por_i};
            pwr_sync <= pwr_meta;
            pwr_q <= pwr_sync;
        end
    end

    // ==========================================================
    // pin only read
    assign pin_bus.raw_pin = ext_reset_pin_i;

    rscu_pin_filter #(
        .FILT_CYCLES(FILT_CYCLES)
    ) u_filter (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .pin(pin_bus.filter)
    );

    assign pin_en = cfg[CFG_EXT_RESET_EN] | cfg[CFG_LV_PROG_EN];
    assign pin_rst = pin_en & pin_bus.filt_low;

    // ==========================================================
    // Event decoding
    assign cold_hold = pwr_sync[0] | pwr_sync[1] | pwr_sync[2];
    assign por_ev = pwr_sync[0] & ~pwr_q[0];
    assign bor_ev = pwr_sync[1] & ~pwr_q[1] & ~pwr_sync[0];
    assign prog_exit = pwr_q[2] & ~pwr_sync[2];
    assign running = (state == ST_RUN) & ~cold_hold;
    assign wdt_expire = running & cfg[CFG_WDT_EN] &
                        (wdt_cnt >= WDT_MAX - WW'(1));
    // watchdog reset when not cleared in time
    assign wdt_rst = wdt_expire & ~sleep_i & ~pin_rst;
    assign wdt_wake = wdt_expire & sleep_i & ~pin_rst;
    assign irq_wake = running & sleep_i & irq_wake_i & ~pin_rst &
                      ~wdt_expire;
    assign pin_ev = running & pin_rst;
    assign warm_ok = running & ~sleep_i & ~pin_rst & ~wdt_expire;
    assign instr_ev = warm_ok & reset_instr_i;
    assign ovf_ev = warm_ok & stack_over_i & cfg[CFG_STACK_RESET_EN];
    assign unf_ev = warm_ok & stack_under_i & cfg[CFG_STACK_RESET_EN];

    // ==========================================================
    // power-up delay only when enabled
    // completion of both timers; pin release checked in ST_WAIT
    assign timers_done =
        (~cfg[CFG_POWERUP_TIMER_EN] | (powerup_timer_cnt >= POWERUP_TIMER_MAX)) &
        (~cfg[CFG_OST_NEEDED] | (ost_cnt >= OST_MAX));

    // Next sequencer state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_COLD: begin
                if (!cold_hold) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cold_hold) begin
                    next_state = ST_COLD;
                end else if (timers_done && !pin_rst) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cold_hold) begin
                    next_state = ST_COLD;
                end else if (pin_ev || wdt_rst || instr_ev ||
                             ovf_ev || unf_ev) begin
                    next_state = ST_WARM;
                end
            end
            ST_WARM: begin
                if (cold_hold) begin
                    next_state = ST_COLD;
                end else if (!pin_rst) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_COLD;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            powerup_timer_cnt <= '0;
            ost_cnt <= '0;
        end else if (state != ST_WAIT) begin
            powerup_timer_cnt <= '0;
            ost_cnt <= '0;
        end else begin
            if (powerup_timer_cnt < POWERUP_TIMER_MAX) begin
                powerup_timer_cnt <= powerup_timer_cnt + PW'(1);
            end
            if (ost_cnt < OST_MAX) begin
                ost_cnt <= ost_cnt + OW'(1);
            end
        end
    end

    // Watchdog counter, cleared by its instruction
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wdt_cnt <= '0;
        end else if (!running || watchdog_clear_instr_i || wdt_expire) begin
            wdt_cnt <= '0;
        end else if (cfg[CFG_WDT_EN]) begin
            wdt_cnt <= wdt_cnt + WW'(1);
        end
    end

    // ==========================================================
    // Cause register: software write, then hardware wins
    always_comb begin
        next_cause = cause;
        if (wr_en && w_lane0 && aw_addr == OFS_CAUSE) begin
            next_cause = w_data[7:0] & CAU_IMPL_MASK;
        end
        if (por_ev || prog_exit) begin
            next_cause = CAU_POR_VAL;
        end else if (bor_ev) begin
            next_cause[CAU_STK_OVER] = 1'b0;
            next_cause[CAU_STK_UNDER] = 1'b0;
            next_cause[CAU_PIN] = 1'b1;
            next_cause[CAU_INSTR] = 1'b1;
            next_cause[CAU_BOR] = 1'b0;
        end else begin
            if (wdt_rst) begin
                next_cause[CAU_WDT] = 1'b0;
            end
            if (pin_ev) begin
                next_cause[CAU_PIN] = 1'b0;
            end
            if (instr_ev) begin
                next_cause[CAU_INSTR] = 1'b0;
            end
            if (ovf_ev) begin
                next_cause[CAU_STK_OVER] = 1'b1;
            end
            if (unf_ev) begin
                next_cause[CAU_STK_UNDER] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cause <= CAU_POR_VAL;
        end else begin
            cause <= next_cause;
        end
    end

    // Timeout and powerdown status flags
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (por_ev || bor_ev || prog_exit) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (wdt_rst) begin
            timeout_flag <= 1'b0;
        end else if (wdt_wake) begin
            timeout_flag <= 1'b0;
            powerdown_flag <= 1'b0;
        end else if (irq_wake || (pin_ev && sleep_i)) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Core control outputs
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            core_reset_o <= 1'b1;
            wake_resume_o <= 1'b0;
            irq_vector_o <= 1'b0;
            pc_target_o <= PC_RESTART;
            pullup_en_o <= 1'b1;
        end else begin
            core_reset_o <= (next_state != ST_RUN);
            wake_resume_o <= wdt_wake | irq_wake;
            irq_vector_o <= irq_wake & global_irq_enable_i;
            if (irq_wake && global_irq_enable_i) begin
                pc_target_o <= PC_IRQ_VECTOR;
            end else if (next_state != ST_RUN) begin
                pc_target_o <= PC_RESTART;
            end
            pullup_en_o <= pin_en | cfg[CFG_SW_PULLUP];
        end
    end

    // ==========================================================
    // AXI4-Lite write path
    assign wr_en = aw_got & w_got & ~s_axi_bvalid_o;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_addr <= s_axi_awaddr_i;
                aw_got <= 1'b1;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_data <= s_axi_wdata_i;
                w_lane0 <= s_axi_wstrb_i[0];
                w_got <= 1'b1;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_en) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr == OFS_CONFIG ||
                                  aw_addr == OFS_CAUSE ||
                                  aw_addr == OFS_STATUS) ?
                                 RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // Config register write
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
        end else if (wr_en && w_lane0 && aw_addr == OFS_CONFIG) begin
            cfg <= w_data[6:0];
        end
    end

    // ==========================================================
    // AXI4-Lite read path
    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr_i)
            OFS_CONFIG: rd_mux[6:0] = cfg;
            OFS_CAUSE: rd_mux[7:0] = cause;
            OFS_STATUS: begin
                rd_mux[STA_TIMEOUT] = timeout_flag;
                rd_mux[STA_POWERDOWN] = powerdown_flag;
                rd_mux[STA_PIN_EN] = pin_en;
                rd_mux[STA_PIN_LEVEL] = pin_bus.sync_level;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_mux;
            s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- verif/rscu_top_props.sv
// Checker on the reset controller top ports
`timescale 1ns/1ps
`default_nettype none
module rscu_top_props (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Watched ports
    input wire logic por_i,
    input wire logic prog_mode_i,
    input wire logic ext_reset_pin_i,
    input wire logic pullup_en_o,
    input wire logic reset_instr_i,
    input wire logic sleep_i,
    input wire logic core_reset_o,
    input wire logic wake_resume_o,
    input wire logic irq_vector_o,
    input wire logic [15:0] pc_target_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // ==========================================
    // Reset sources and restart points
    property p_ins;
        reset_instr_i && !core_reset_o && !sleep_i |-> ##[1:2] core_reset_o;
    endproperty
    a_ins: assert property (p_ins) else $error("instr reset");
    property p_pc;
        $fell(core_reset_o) |-> pc_target_o == 16'h0000;
    endproperty
    a_pc: assert property (p_pc) else $error("restart pc");
    property p_vec;
        irq_vector_o |-> ##[0:1] pc_target_o == 16'h0004;
    endproperty
    a_vec: assert property (p_vec) else $error("vector pc");
    property p_wak;
        wake_resume_o |-> !core_reset_o ##1 !wake_resume_o;
    endproperty
    a_wak: assert property (p_wak) else $error("wake pulse");
    property p_por;
        por_i |-> ##[1:4] core_reset_o;
    endproperty
    a_por: assert property (p_por) else $error("power-on");
    property p_prg;
        $fell(prog_mode_i) |-> core_reset_o [*4];
    endproperty
    a_prg: assert property (p_prg) else $error("prog exit");
    property p_pin;
        (!ext_reset_pin_i && pullup_en_o) [*8] |-> ##[0:2] core_reset_o;
    endproperty
    a_pin: assert property (p_pin) else $error("pin held");
    property p_sht;
        !core_reset_o && ext_reset_pin_i ##1 !ext_reset_pin_i
            ##1 ext_reset_pin_i |-> !core_reset_o [*8];
    endproperty
    a_sht: assert property (p_sht) else $error("pin glitch");
    // Main scenarios reached
    c_ins: cover property (reset_instr_i && !core_reset_o);
    c_wak: cover property (wake_resume_o);
    c_vec: cover property (irq_vector_o);
endmodule
bind rscu_top rscu_top_props i_props (.*);
`default_nettype wire

//--- verif/rscu_far_model.sv
// Far side: reset pin with pull-up and core watchdog clears
`timescale 1ns/1ps
`default_nettype none
module rscu_far_model (
    // Clock, reset and commands
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic kick_en_i,
    input wire logic pin_low_i,
    // Toward the controller
    output logic clr_o,
    output logic pin_o
);
    logic [5:0] cnt;
    assign pin_o = !pin_low_i;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 6'h00;
            clr_o <= 1'b0;
        end else begin
            cnt <= cnt + 6'h01;
            clr_o <= kick_en_i && cnt == 6'h00;
        end
    end
endmodule
`default_nettype wire

//--- verif/rscu_top_tb.sv
// Self-checking bench for the reset controller
`timescale 1ns/1ps
`default_nettype none
module rscu_top_tb;
    logic clk, rstn, awv, wv, bre, arv, rre, por, bor, prg;
    logic slp, irq, global_irq_enable, kick, plow, awr, wrd, bv, arr, rv, pu;
    logic crst, wake, vec, clr, pin;
    logic [2:0] ev;
    logic [7:0] awa, ara;
    logic [1:0] br, rr;
    logic [31:0] wd, rdat;
    logic [15:0] pc;
    int errors, n_compared, n;
    rscu_top #(.POWERUP_TIMER_CYCLES(50), .OST_CYCLES(20), .WDT_CYCLES(100),
        .FILT_CYCLES(4)) i_dut (.sys_clk_i(clk), .rstn_i(rstn),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .por_i(por), .bor_i(bor),
        .prog_mode_i(prg), .ext_reset_pin_i(pin), .pullup_en_o(pu),
        .watchdog_clear_instr_i(clr), .reset_instr_i(ev[0]),
        .stack_over_i(ev[1]), .stack_under_i(ev[2]), .sleep_i(slp),
        .irq_wake_i(irq), .global_irq_enable_i(global_irq_enable), .core_reset_o(crst),
        .wake_resume_o(wake), .irq_vector_o(vec), .pc_target_o(pc));
    rscu_far_model i_far (.clk_i(clk), .rst_n_i(rstn), .kick_en_i(kick),
        .pin_low_i(plow), .clr_o(clr), .pin_o(pin));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================
    // Checks, verdict and bus tasks
    task automatic chk(input string s, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("Error %s exp %h got %h", s, e, g);
        end
    endtask
    task print_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task tmo();
        errors++;
        print_verdict();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wrd === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 99);
        bre <= 1'b0;
        if (n >= 99) tmo();
        chk("bresp", 32'h0, 32'(br));
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 99);
        rre <= 1'b0;
        if (n >= 99) tmo();
        chk("rresp", 32'(r), 32'(rr));
        chk("rdata", e, rdat);
        @(posedge clk);
    endtask
    // Wait for reset (w=0) or wake (w=1) to be v
    task automatic wt(input logic w, input logic v, input int lim);
        n = 0;
        while ((w ? wake : crst) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) tmo();
    endtask
    task automatic pulse(input logic [2:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
        repeat (4) @(posedge clk);
        wt(0, 0, 60);
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        tmo();
    end
    // Main sequence
    initial begin
        {awv, wv, bre, arv, rre, por, bor, prg, slp, irq, global_irq_enable} = 11'h000;
        {plow, ev, awa, ara, wd} = 52'h0;
        kick = 1'b1;
        rstn = 1'b0;
        errors = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        wt(0, 0, 200);
        rd(8'h04, 32'h1C, 2'h0);
        rd(8'h08, 32'h1B, 2'h0);
        rd(8'h00, 32'h39, 2'h0);
        rd(8'h10, 32'h00, 2'h2);
        wr(8'h04, 32'hFF);
        rd(8'h04, 32'hDF, 2'h0);
        wr(8'h04, 32'h1F);
        pulse(3'h1);
        rd(8'h04, 32'h1B, 2'h0);
        wr(8'h00, 32'h3D);
        pulse(3'h2);
        rd(8'h04, 32'h9B, 2'h0);
        pulse(3'h4);
        rd(8'h04, 32'hDB, 2'h0);
        $display("end warm resets");
        plow <= 1'b1;
        @(posedge clk);
        plow <= 1'b0;
        repeat (12) @(posedge clk);
        chk("glitch", 32'h0, 32'(crst));
        plow <= 1'b1;
        repeat (20) @(posedge clk);
        chk("held", 32'h1, 32'(crst));
        plow <= 1'b0;
        wt(0, 0, 30);
        rd(8'h04, 32'hD3, 2'h0);
        rd(8'h08, 32'h1B, 2'h0);
        kick <= 1'b0;
        wt(0, 1, 300);
        kick <= 1'b1;
        wt(0, 0, 30);
        rd(8'h04, 32'hC3, 2'h0);
        rd(8'h08, 32'h0B, 2'h0);
        $display("end pin and watchdog");
        global_irq_enable <= 1'b1;
        slp <= 1'b1;
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        wt(1, 1, 20);
        chk("vec", 32'h1, 32'(vec));
        repeat (2) @(posedge clk);
        slp <= 1'b0;
        chk("pc", 32'h4, 32'(pc));
        rd(8'h08, 32'h13, 2'h0);
        kick <= 1'b0;
        slp <= 1'b1;
        wt(1, 1, 300);
        slp <= 1'b0;
        kick <= 1'b1;
        rd(8'h08, 32'h03, 2'h0);
        rd(8'h04, 32'hC3, 2'h0);
        $display("end wake");
        wr(8'h00, 32'h38);
        plow <= 1'b1;
        repeat (20) @(posedge clk);
        chk("off", 32'h0, 32'(crst));
        chk("pull", 32'h0, 32'(pu));
        rd(8'h08, 32'h00, 2'h0);
        plow <= 1'b0;
        wr(8'h00, 32'h78);
        chk("pull", 32'h1, 32'(pu));
        wr(8'h00, 32'h3A);
        rd(8'h08, 32'h03, 2'h0);
        $display("end pin config");
        por <= 1'b1;
        repeat (4) @(posedge clk);
        por <= 1'b0;
        wt(0, 0, 200);
        rd(8'h04, 32'h1C, 2'h0);
        wr(8'h04, 32'h1F);
        plow <= 1'b1;
        prg <= 1'b1;
        repeat (4) @(posedge clk);
        prg <= 1'b0;
        repeat (150) @(posedge clk);
        chk("hold", 32'h1, 32'(crst));
        plow <= 1'b0;
        wt(0, 0, 12);
        rd(8'h04, 32'h1C, 2'h0);
        wr(8'h00, 32'h31);
        wr(8'h04, 32'h1F);
        bor <= 1'b1;
        repeat (4) @(posedge clk);
        bor <= 1'b0;
        wt(0, 0, 40);
        rd(8'h04, 32'h1E, 2'h0);
        $display("end cold starts");
        print_verdict();
    end
endmodule
`default_nettype wire
